// >>> ofd_pkg.sv
// Shared constants and types for the opcode operand field decoder.
// Assumes one clock domain and that the fetch unit flags each word's format.
package ofd_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned FILE_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned BIT_W   = 3;
  localparam int unsigned LIT_W   = 20;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned BUS_A_W = 8;

  // ----------------------------------------------------------------------
  // Field positions within an instruction word
  // ----------------------------------------------------------------------
  localparam int unsigned POS_DEST   = 9;
  localparam int unsigned POS_ACCESS = 8;
  localparam int unsigned POS_BIT_LO = 9;
  localparam int unsigned POS_MARK   = 12;

  // Second word of a two-word instruction carries all ones on top
  localparam logic [3:0]        SECOND_MARK = 4'hF;

  // ----------------------------------------------------------------------
  // Access region mapping
  // ----------------------------------------------------------------------
  localparam logic [FILE_W-1:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [BUS_A_W-1:0] REG_BANK    = 8'h00;
  localparam logic [BUS_A_W-1:0] REG_ACCUM   = 8'h04;
  localparam logic [BUS_A_W-1:0] REG_STATUS  = 8'h08;
  localparam logic [BUS_A_W-1:0] REG_LITERAL = 8'h0C;
  localparam int unsigned        STAT_PEND   = 0;
  localparam int unsigned        STAT_ERR    = 1;
  localparam logic [BANK_W-1:0]  BANK_RST    = 4'h0;
  localparam logic [FILE_W-1:0]  ACCUM_RST   = 8'h00;
  localparam logic [FILE_W-1:0]  BIT_ONE     = 8'h01;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_BYTE  = 3'h0,
    FMT_BIT   = 3'h1,
    FMT_LIT8  = 3'h2,
    FMT_LIT12 = 3'h3,
    FMT_LIT20 = 3'h4,
    FMT_MOVE  = 3'h5
  } ofd_fmt_type;

  typedef enum logic [1:0] {
    ST_WORD1 = 2'b01,
    ST_WORD2 = 2'b10
  } ofd_st_type;

  typedef enum logic [1:0] {
    WB_NONE = 2'h0,
    WB_ACC  = 2'h1,
    WB_FILE = 2'h2
  } ofd_wb_type;

  typedef struct packed {
    logic              valid;
    ofd_fmt_type       fmt;
    logic [WORD_W-1:0] word;
  } ofd_instr_type;

  typedef struct packed {
    logic              valid;
    logic [FILE_W-1:0] data;
  } ofd_result_type;

  typedef struct packed {
    logic              valid;
    ofd_fmt_type       fmt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] target;
    logic              dest_file;
    logic [BIT_W-1:0]  bit_num;
    logic [FILE_W-1:0] bit_mask;
    logic [LIT_W-1:0]  literal;
  } ofd_decode_type;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [FILE_W-1:0] data;
  } ofd_mem_wr_type;

  typedef struct packed {
    ofd_st_type        st;
    ofd_fmt_type       pend_fmt;
    logic [ADDR_W-1:0] first;
    logic [BANK_W-1:0] bank;
    logic [FILE_W-1:0] accum;
    ofd_wb_type        wb;
    logic [ADDR_W-1:0] wb_addr;
    logic              err;
    ofd_decode_type    dec;
    ofd_mem_wr_type    mem_wr;
    logic [DATA_W-1:0] rdata;
  } ofd_state_type;

endpackage : ofd_pkg

// >>> ofd_addr_resolve.sv
// Resolves an 8-bit file address to a full data memory address.
// Assumes a combinational path; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none

module ofd_addr_resolve (
  input  wire logic [ofd_pkg::FILE_W-1:0] file_addr_i,
  input  wire logic                       access_sel_i,
  input  wire logic [ofd_pkg::BANK_W-1:0] bank_i,
  output var  logic [ofd_pkg::ADDR_W-1:0] addr_o
);

  always_comb begin
    if (access_sel_i) begin
      addr_o = {bank_i, file_addr_i};
    end else if (file_addr_i < ofd_pkg::ACCESS_SPLIT) begin
      addr_o = {ofd_pkg::ACCESS_LO_BANK, file_addr_i};
    end else begin
      addr_o = {ofd_pkg::ACCESS_HI_BANK, file_addr_i};
    end
  end

endmodule : ofd_addr_resolve

`default_nettype wire

// >>> ofd_decoder.sv
// Operand field decoder: turns instruction words into addresses, bit
// selects and literals, and steers results to the accumulator or memory.
// Assumes fetch logic on the same clock tags each word with its format.
//
// Overview of operation
// - Byte operations: destination bit 0 sends result to accumulator, else to file register.
// - Access bit 0 maps address into access region, bank pointer ignored.
// - A bank pointer register selects the current RAM bank.
// - Bit instructions decode a three-bit number selecting bit 0 to 7.
// - Single-word file operations take an 8-bit address 0x00 to 0xFF.
// - Moves decode a 12-bit source address over full memory, no bank.
// - Moves decode a 12-bit target address and write the byte there.
// - Literal fields of 8, 12 or 20 bits are accepted.
`timescale 1ns/100ps
`default_nettype none

module ofd_decoder (
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire ofd_pkg::ofd_instr_type      instr_i,
  input  wire ofd_pkg::ofd_result_type     result_i,
  input  wire logic [ofd_pkg::BUS_A_W-1:0] addr_i,
  input  wire logic [ofd_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output var  logic [ofd_pkg::DATA_W-1:0]  rdata_o,
  output var  ofd_pkg::ofd_decode_type     dec_o,
  output var  ofd_pkg::ofd_mem_wr_type     mem_wr_o,
  output var  logic [ofd_pkg::FILE_W-1:0]  accumulator_o,
  output var  logic [ofd_pkg::BANK_W-1:0]  bank_pointer_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ofd_pkg::ofd_state_type           r_reg;
  ofd_pkg::ofd_state_type           r_next;
  logic [ofd_pkg::ADDR_W-1:0]       res_addr;
  logic [ofd_pkg::WORD_W-1:0]       w;
  logic [ofd_pkg::BIT_W-1:0]        bnum;

  assign w    = instr_i.word;
  assign bnum = w[ofd_pkg::POS_BIT_LO +: ofd_pkg::BIT_W];

  ofd_addr_resolve u_resolve (
    .file_addr_i  (w[ofd_pkg::FILE_W-1:0]),
    .access_sel_i (w[ofd_pkg::POS_ACCESS]),
    .bank_i       (r_reg.bank),
    .addr_o       (res_addr)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_next              = r_reg;
    r_next.dec.valid    = 1'b0;
    r_next.mem_wr.wr    = 1'b0;
    r_next.rdata        = '0;

    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        ofd_pkg::REG_BANK: begin
          r_next.bank = wdata_i[ofd_pkg::BANK_W-1:0];
        end
        ofd_pkg::REG_ACCUM: begin
          r_next.accum = wdata_i[ofd_pkg::FILE_W-1:0];
        end
        ofd_pkg::REG_STATUS: begin
          if (wdata_i[ofd_pkg::STAT_ERR]) begin
            r_next.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, unmapped reads return zero
    if (rd_i) begin
      unique case (addr_i)
        ofd_pkg::REG_BANK: begin
          r_next.rdata[ofd_pkg::BANK_W-1:0] = r_reg.bank;
        end
        ofd_pkg::REG_ACCUM: begin
          r_next.rdata[ofd_pkg::FILE_W-1:0] = r_reg.accum;
        end
        ofd_pkg::REG_STATUS: begin
          r_next.rdata[ofd_pkg::STAT_PEND] = (r_reg.st == ofd_pkg::ST_WORD2);
          r_next.rdata[ofd_pkg::STAT_ERR]  = r_reg.err;
        end
        ofd_pkg::REG_LITERAL: begin
          r_next.rdata[ofd_pkg::LIT_W-1:0] = r_reg.dec.literal;
        end
        default: begin
        end
      endcase
    end

    // Result write-back; a result in the same cycle as a new decode
    // still uses the previous instruction's destination
    if (result_i.valid) begin
      unique case (r_reg.wb)
        ofd_pkg::WB_ACC: begin
          r_next.accum = result_i.data;
        end
        ofd_pkg::WB_FILE: begin
          r_next.mem_wr.wr   = 1'b1;
          r_next.mem_wr.addr = r_reg.wb_addr;
          r_next.mem_wr.data = result_i.data;
        end
        default: begin
        end
      endcase
      r_next.wb = ofd_pkg::WB_NONE;
    end

    // Decode
    unique case (r_reg.st)
      ofd_pkg::ST_WORD1: begin
        if (instr_i.valid) begin
          r_next.dec.fmt       = instr_i.fmt;
          r_next.dec.dest_file = 1'b0;
          r_next.dec.bit_num   = '0;
          r_next.dec.bit_mask  = '0;
          r_next.dec.target    = '0;
          unique case (instr_i.fmt)
            ofd_pkg::FMT_BYTE: begin
              r_next.dec.valid     = 1'b1;
              r_next.dec.addr      = res_addr;
              r_next.dec.dest_file = w[ofd_pkg::POS_DEST];
              r_next.wb_addr       = res_addr;
              r_next.wb            = w[ofd_pkg::POS_DEST] ? ofd_pkg::WB_FILE
                                                          : ofd_pkg::WB_ACC;
            end
            ofd_pkg::FMT_BIT: begin
              r_next.dec.valid     = 1'b1;
              r_next.dec.addr      = res_addr;
              r_next.dec.dest_file = 1'b1;
              r_next.dec.bit_num   = bnum;
              r_next.dec.bit_mask  = ofd_pkg::BIT_ONE << bnum;
              r_next.wb_addr       = res_addr;
              r_next.wb            = ofd_pkg::WB_FILE;
            end
            ofd_pkg::FMT_LIT8: begin
              r_next.dec.valid   = 1'b1;
              r_next.dec.literal = {{(ofd_pkg::LIT_W - ofd_pkg::FILE_W){1'b0}},
                                    w[ofd_pkg::FILE_W-1:0]};
              r_next.wb          = ofd_pkg::WB_ACC;
            end
            ofd_pkg::FMT_LIT12: begin
              r_next.dec.valid   = 1'b1;
              r_next.dec.literal = {{(ofd_pkg::LIT_W - ofd_pkg::ADDR_W){1'b0}},
                                    w[ofd_pkg::ADDR_W-1:0]};
              r_next.wb          = ofd_pkg::WB_NONE;
            end
            default: begin
              // Two-word formats: literal 20 and register move
              r_next.first    = w[ofd_pkg::ADDR_W-1:0];
              r_next.pend_fmt = instr_i.fmt;
              r_next.st       = ofd_pkg::ST_WORD2;
            end
          endcase
        end
      end
      ofd_pkg::ST_WORD2: begin
        if (instr_i.valid) begin
          r_next.st = ofd_pkg::ST_WORD1;
          if (w[ofd_pkg::POS_MARK +: $bits(ofd_pkg::SECOND_MARK)] == ofd_pkg::SECOND_MARK) begin
            r_next.dec.valid     = 1'b1;
            r_next.dec.fmt       = r_reg.pend_fmt;
            r_next.dec.dest_file = 1'b0;
            r_next.dec.bit_num   = '0;
            r_next.dec.bit_mask  = '0;
            if (r_reg.pend_fmt == ofd_pkg::FMT_MOVE) begin
              r_next.dec.addr      = r_reg.first;
              r_next.dec.target    = w[ofd_pkg::ADDR_W-1:0];
              r_next.dec.dest_file = 1'b1;
              r_next.wb_addr       = w[ofd_pkg::ADDR_W-1:0];
              r_next.wb            = ofd_pkg::WB_FILE;
            end else begin
              // Low byte from the first word, upper twelve from the second
              r_next.dec.literal = {w[ofd_pkg::ADDR_W-1:0],
                                    r_reg.first[ofd_pkg::FILE_W-1:0]};
              r_next.dec.target  = '0;
              // Wide literals arm no write-back, a stale one must not fire
              r_next.wb          = ofd_pkg::WB_NONE;
            end
          end else begin
            // Broken pair: drop it, hardware set beats a software clear
            r_next.err = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r_reg       <= '0;
      r_reg.st    <= ofd_pkg::ST_WORD1;
      r_reg.bank  <= ofd_pkg::BANK_RST;
      r_reg.accum <= ofd_pkg::ACCUM_RST;
      r_reg.wb    <= ofd_pkg::WB_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata_o        = r_reg.rdata;
  assign dec_o          = r_reg.dec;
  assign mem_wr_o       = r_reg.mem_wr;
  assign accumulator_o  = r_reg.accum;
  assign bank_pointer_o = r_reg.bank;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_move_first;
    instr_i.valid && instr_i.fmt == ofd_pkg::FMT_MOVE && r_reg.st == ofd_pkg::ST_WORD1;
  endsequence

  sequence s_second_good;
    instr_i.valid && r_reg.st == ofd_pkg::ST_WORD2
      && instr_i.word[ofd_pkg::POS_MARK +: $bits(ofd_pkg::SECOND_MARK)] == ofd_pkg::SECOND_MARK;
  endsequence

  a_acc_dest: assert property (
    result_i.valid && r_reg.wb == ofd_pkg::WB_ACC && !wr_i
      |=> accumulator_o == $past(result_i.data) && !mem_wr_o.wr)
    else $error("result not placed in accumulator");

  a_file_dest: assert property (
    result_i.valid && r_reg.wb == ofd_pkg::WB_FILE
      |=> mem_wr_o.wr && mem_wr_o.addr == $past(r_reg.wb_addr))
    else $error("result not written to file register");

  a_access_low: assert property (
    r_reg.st == ofd_pkg::ST_WORD1 && instr_i.valid && instr_i.fmt == ofd_pkg::FMT_BYTE
      && !instr_i.word[ofd_pkg::POS_ACCESS] && instr_i.word[7:0] < ofd_pkg::ACCESS_SPLIT
      |=> dec_o.addr[11:8] == ofd_pkg::ACCESS_LO_BANK)
    else $error("access address used bank pointer");

  a_banked_addr: assert property (
    r_reg.st == ofd_pkg::ST_WORD1 && instr_i.valid && instr_i.fmt == ofd_pkg::FMT_BIT
      && instr_i.word[ofd_pkg::POS_ACCESS]
      |=> dec_o.valid && dec_o.addr == {$past(bank_pointer_o), $past(instr_i.word[7:0])})
    else $error("banked address wrong");

  a_bank_write: assert property (
    wr_i && addr_i == ofd_pkg::REG_BANK
      |=> bank_pointer_o == $past(wdata_i[3:0]) ##1 1'b1)
    else $error("bank pointer not updated");

  a_bit_select: assert property (
    r_reg.st == ofd_pkg::ST_WORD1 && instr_i.valid && instr_i.fmt == ofd_pkg::FMT_BIT
      |=> dec_o.bit_num == $past(instr_i.word[11:9]) && $onehot(dec_o.bit_mask))
    else $error("bit select wrong");

  a_file_field: assert property (
    r_reg.st == ofd_pkg::ST_WORD1 && instr_i.valid && instr_i.fmt == ofd_pkg::FMT_BYTE
      |=> dec_o.valid && dec_o.addr[7:0] == $past(instr_i.word[7:0]))
    else $error("file address field lost");

  a_move_source: assert property (
    s_move_first ##[1:5] s_second_good
      |=> dec_o.valid && dec_o.addr == $past(r_reg.first))
    else $error("move source wrong");

  a_move_target: assert property (
    (s_second_good and (r_reg.pend_fmt == ofd_pkg::FMT_MOVE))
      |=> dec_o.target == $past(instr_i.word[11:0]) && r_reg.wb == ofd_pkg::WB_FILE)
    else $error("move target wrong");

  a_literal_20: assert property (
    (s_second_good and (r_reg.pend_fmt == ofd_pkg::FMT_LIT20))
      |=> dec_o.literal == {$past(instr_i.word[11:0]), $past(r_reg.first[7:0])})
    else $error("wide literal wrong");

  a_move_latch: assert property (
    s_move_first |=> r_reg.first == $past(instr_i.word[11:0]))
    else $error("move source not latched");

  a_mask_match: assert property (
    r_reg.st == ofd_pkg::ST_WORD1 && instr_i.valid && instr_i.fmt == ofd_pkg::FMT_BIT
      |=> dec_o.bit_mask == (ofd_pkg::BIT_ONE << $past(instr_i.word[11:9])))
    else $error("bit mask does not match bit number");

  a_access_high: assert property (
    r_reg.st == ofd_pkg::ST_WORD1 && instr_i.valid && instr_i.fmt == ofd_pkg::FMT_BYTE
      && !instr_i.word[ofd_pkg::POS_ACCESS] && instr_i.word[7:0] >= ofd_pkg::ACCESS_SPLIT
      |=> dec_o.addr[11:8] == ofd_pkg::ACCESS_HI_BANK)
    else $error("upper access address used bank pointer");

  a_wide_quiet: assert property (
    (s_second_good and (r_reg.pend_fmt == ofd_pkg::FMT_LIT20))
      |=> r_reg.wb == ofd_pkg::WB_NONE)
    else $error("wide literal armed a write-back");

endmodule : ofd_decoder

`default_nettype wire

// >>> ofd_core_model.sv
// Core-side model: fetch unit that issues words and results, plus data memory.
// Assumes the decoder's clock; the bench calls its tasks in sequence.
`timescale 1ns/100ps
`default_nettype none

module ofd_core_model (
  input  wire logic                    clk_i,
  input  wire ofd_pkg::ofd_mem_wr_type mem_wr_i,
  output var  ofd_pkg::ofd_instr_type  instr_o,
  output var  ofd_pkg::ofd_result_type result_o
);
  logic [7:0] mem [0:4095];

  initial begin
    instr_o  = '0;
    result_o = '0;
  end

  // ----------------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (mem_wr_i.wr) begin
      mem[mem_wr_i.addr] <= mem_wr_i.data;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch side
  // ----------------------------------------------------------------------
  // Released word and data flip (fmt is held), so a stale word never looks valid by luck
  task automatic send_word(input ofd_pkg::ofd_fmt_type fmt, input logic [15:0] word);
    @(posedge clk_i);
    instr_o <= '{valid: 1'b1, fmt: fmt, word: word};
    @(posedge clk_i);
    instr_o <= '{valid: 1'b0, fmt: fmt, word: ~word};
    #1;
  endtask : send_word

  task automatic send_result(input logic [7:0] data);
    @(posedge clk_i);
    result_o <= '{valid: 1'b1, data: data};
    @(posedge clk_i);
    result_o <= '{valid: 1'b0, data: ~data};
    #1;
  endtask : send_result
endmodule : ofd_core_model

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the operand field decoder.
// Assumes the core model drives the instruction and result ports.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic                    clk_i;
  logic                    rst_b_i;
  logic                    wr_i;
  logic                    rd_i;
  logic [7:0]              addr_i;
  logic [31:0]             wdata_i;
  logic [31:0]             rdata_o;
  logic [31:0]             rv;
  ofd_pkg::ofd_instr_type  instr;
  ofd_pkg::ofd_result_type result;
  ofd_pkg::ofd_decode_type dec;
  ofd_pkg::ofd_mem_wr_type mem_wr;
  logic [7:0]              acc;
  logic [3:0]              bank;
  int                      n_errors;
  int                      n_tests;

  ofd_core_model u_core (.clk_i(clk_i), .mem_wr_i(mem_wr), .instr_o(instr), .result_o(result));

  ofd_decoder u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr), .result_i(result),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .dec_o(dec), .mem_wr_o(mem_wr), .accumulator_o(acc), .bank_pointer_o(bank)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : bus_rd

  // Bounded; the decode pulse is due right after the taking edge
  task automatic wait_dec();
    for (int i = 0; i < 4; i++) begin
      if (dec.valid === 1'b1) return;
      @(posedge clk_i);
      #1;
    end
    n_errors++;
    close_out();
  endtask : wait_dec

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    bus_rd(ofd_pkg::REG_BANK, rv);
    chk(rv, 32'h0);
    bus_wr(ofd_pkg::REG_BANK, 32'h0000_001F);
    bus_rd(ofd_pkg::REG_BANK, rv);
    chk(rv, 32'h0000_000F);
    bus_wr(8'h10, 32'h0000_0003);
    bus_rd(8'h10, rv);
    chk(rv, 32'h0);
    bus_rd(ofd_pkg::REG_BANK, rv);
    chk(rv, 32'h0000_000F);
    bus_wr(ofd_pkg::REG_BANK, 32'h0000_0002);
    #1;
    chk(32'(bank), 32'h2);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_byte_banked();
    u_core.send_word(ofd_pkg::FMT_BYTE, 16'h0312);
    wait_dec();
    chk(32'(dec.addr), 32'h212);
    chk(32'(dec.dest_file), 32'h1);
    @(posedge clk_i);
    #1;
    chk(32'(dec.valid), 32'h0);
    u_core.send_result(8'hAA);
    chk({mem_wr.wr, 7'h0, mem_wr.addr, 4'h0, mem_wr.data}, 32'h8021_20AA);
    @(posedge clk_i);
    #1;
    chk(32'(u_core.mem[12'h212]), 32'hAA);
    $display("t_byte_banked done");
  endtask : t_byte_banked

  task automatic t_byte_access();
    u_core.send_word(ofd_pkg::FMT_BYTE, 16'h0045);
    wait_dec();
    chk(32'(dec.addr), 32'h045);
    u_core.send_word(ofd_pkg::FMT_BYTE, 16'h0085);
    wait_dec();
    chk(32'(dec.addr), 32'hF85);
    u_core.send_word(ofd_pkg::FMT_BYTE, 16'h00FF);
    wait_dec();
    chk(32'(dec.addr), 32'hFFF);
    chk(32'(dec.dest_file), 32'h0);
    u_core.send_result(8'h5A);
    chk(32'(mem_wr.wr), 32'h0);
    chk(32'(acc), 32'h5A);
    $display("t_byte_access done");
  endtask : t_byte_access

  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      u_core.send_word(ofd_pkg::FMT_BIT, 16'(b << 9) | 16'h0110);
      wait_dec();
      chk(32'(dec.bit_num), 32'(b));
      chk(32'(dec.bit_mask), 32'h1 << b);
      chk(32'(dec.addr), 32'h210);
    end
    $display("t_bits done");
  endtask : t_bits

  task automatic t_move();
    u_core.send_word(ofd_pkg::FMT_MOVE, 16'h0123);
    chk(32'(dec.valid), 32'h0);
    bus_rd(ofd_pkg::REG_STATUS, rv);
    chk(rv, 32'h1);
    u_core.send_word(ofd_pkg::FMT_MOVE, 16'hFFED);
    wait_dec();
    chk({8'h0, dec.addr, dec.target}, 32'h0012_3FED);
    u_core.send_result(8'h3C);
    chk({mem_wr.wr, 7'h0, mem_wr.addr, 4'h0, mem_wr.data}, 32'h80FE_D03C);
    $display("t_move done");
  endtask : t_move

  task automatic t_literals();
    u_core.send_word(ofd_pkg::FMT_LIT8, 16'h0F77);
    wait_dec();
    chk(32'(dec.literal), 32'h77);
    u_core.send_result(8'h33);
    chk(32'(acc), 32'h33);
    u_core.send_word(ofd_pkg::FMT_LIT12, 16'h0ABC);
    wait_dec();
    chk(32'(dec.literal), 32'hABC);
    u_core.send_word(ofd_pkg::FMT_LIT20, 16'h00AB);
    u_core.send_word(ofd_pkg::FMT_LIT20, 16'hFCDE);
    wait_dec();
    chk(32'(dec.literal), 32'hCDEAB);
    bus_rd(ofd_pkg::REG_LITERAL, rv);
    chk(rv, 32'hCDEAB);
    $display("t_literals done");
  endtask : t_literals

  // Second word without the all-ones mark must drop the pair
  task automatic t_broken();
    u_core.send_word(ofd_pkg::FMT_LIT20, 16'h0011);
    u_core.send_word(ofd_pkg::FMT_LIT20, 16'h1234);
    chk(32'(dec.valid), 32'h0);
    bus_rd(ofd_pkg::REG_STATUS, rv);
    chk(rv, 32'h2);
    bus_wr(ofd_pkg::REG_STATUS, 32'h2);
    bus_rd(ofd_pkg::REG_STATUS, rv);
    chk(rv, 32'h0);
    $display("t_broken done");
  endtask : t_broken

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_errors = 0;
    n_tests  = 0;
    rst_b_i  = 1'b0;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    addr_i   = 8'h00;
    wdata_i  = 32'h0;
    repeat (16) @(posedge clk_i);
    #1;
    chk({acc, 4'h0, bank, 7'h0, dec.valid, 7'h0, mem_wr.wr}, 32'h0);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_byte_banked();
    t_byte_access();
    t_bits();
    t_move();
    t_literals();
    t_broken();
    close_out();
  end
endmodule : tb

`default_nettype wire
